// [core/ipg_pkg.sv]
// Package for the internal PWM generator: register map, field layouts and constants.
package ipg_pkg;

    localparam int DW = 16;
    localparam int AW = 4;
    localparam int CW = 12;
    localparam int MW = 16;
    localparam int PHASES = 3;

    localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
    localparam logic [AW-1:0] ADDR_CAL = 4'h1;
    localparam logic [AW-1:0] ADDR_PERIOD = 4'h2;
    localparam logic [AW-1:0] ADDR_DUTY_A = 4'h3;
    localparam logic [AW-1:0] ADDR_DEAD = 4'h6;
    localparam logic [AW-1:0] ADDR_SYNC_PRD = 4'h7;
    localparam logic [AW-1:0] ADDR_TRIM = 4'h8;

    typedef enum logic [1:0] {
        CNT_UPDOWN = 2'h0,
        CNT_UP = 2'h1,
        CNT_DOWN = 2'h2
    } ipg_cnt_mode_t;

    typedef enum logic [2:0] {
        SYNC_OFF = 3'h0,
        SYNC_MEASURE = 3'h1,
        SYNC_PERIOD = 3'h2,
        SYNC_OSC = 3'h5,
        SYNC_OSC_PERIOD = 3'h6,
        SYNC_SCLK = 3'h7
    } ipg_sync_t;

    typedef struct packed {
        logic [3:0] rsvd;
        logic [2:0] ls_en;
        logic [2:0] hs_en;
        ipg_sync_t sync;
        ipg_cnt_mode_t mode;
        logic en;
    } ipg_ctrl_t;

    typedef struct packed {
        logic [7:0] rsvd;
        logic [3:0] cycles_code;
        logic [3:0] freq_mhz;
    } ipg_cal_t;

    typedef struct packed {
        logic hs;
        logic ls;
    } ipg_gate_t;

    localparam logic [DW-1:0] CTRL_RST = 16'h0fc0;
    localparam logic [DW-1:0] CAL_RST = 16'h0004;
    localparam logic [CW-1:0] PERIOD_RST = 12'h1f4;
    localparam logic [CW-1:0] DUTY_RST = 12'h000;
    localparam logic [7:0] DEAD_RST = 8'h04;
    localparam logic [7:0] TRIM_RST = 8'h80;
    localparam logic [7:0] TRIM_MAX = 8'hff;
    localparam logic [7:0] TRIM_MIN = 8'h00;
    localparam logic [CW-1:0] PRD_MAX = 12'hfff;
    localparam logic [MW-1:0] MEAS_MAX = 16'hffff;

    localparam int SYS_NOM_HZ = 20_000_000;
    localparam int SYNC_CAL_HZ = 20_000;
    localparam logic [MW-1:0] SYNC_CAL_COUNT = MW'(SYS_NOM_HZ / SYNC_CAL_HZ);
    localparam logic [4:0] SYS_NOM_MHZ = 5'(SYS_NOM_HZ / 1_000_000);
    localparam int CAL_CYC_SHIFT = 4;

endpackage

// [core/ipg_core.sv]
// Internal three-phase PWM generator with sync measurement and oscillator calibration.
`timescale 1ns/10ps
`default_nettype none

module ipg_core
    import ipg_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic [ipg_pkg::AW-1:0] reg_addr,
    input wire logic [ipg_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ipg_pkg::DW-1:0] reg_rdata,
    input wire logic phase_b_low_input_pin,
    input wire logic serial_clk_in,
    output ipg_pkg::ipg_gate_t [ipg_pkg::PHASES-1:0] gate_out,
    output logic [7:0] osc_trim
);
    import ipg_pkg::*;

    typedef enum logic [1:0] {
        CAL_WAIT,
        CAL_RUN,
        CAL_ADJ
    } ipg_cal_state_t;

    // Reset is released through two flops so every flop leaves reset on the same edge.
    logic [1:0] rst_sync_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    wire rst_ni = rst_sync_q[1];

    // Register file.
    ipg_ctrl_t ctrl_q;
    ipg_cal_t cal_q;
    logic [CW-1:0] period_q;
    logic [CW-1:0] duty_q [PHASES];
    logic [7:0] dead_q;
    logic [CW-1:0] meas_prd_q;
    logic [7:0] trim_q;
    logic [DW-1:0] rdata_q;

    wire wr_en = reg_wr & ~chip_select_n;
    wire rd_en = reg_rd & ~chip_select_n;
    wire wr_ctrl = wr_en && (reg_addr == ADDR_CTRL);
    wire wr_cal = wr_en && (reg_addr == ADDR_CAL);
    wire wr_period = wr_en && (reg_addr == ADDR_PERIOD);
    wire wr_dead = wr_en && (reg_addr == ADDR_DEAD);

    always_ff @(posedge clock or negedge rst_ni) begin
        if (!rst_ni) begin
            ctrl_q <= ipg_ctrl_t'(CTRL_RST);
            cal_q <= ipg_cal_t'(CAL_RST);
            period_q <= PERIOD_RST;
            dead_q <= DEAD_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= ipg_ctrl_t'(reg_wdata);
            end
            if (wr_cal) begin
                cal_q <= ipg_cal_t'(reg_wdata);
            end
            if (wr_period) begin
                period_q <= reg_wdata[CW-1:0];
            end
            if (wr_dead) begin
                dead_q <= reg_wdata[7:0];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PHASES; gi++) begin : g_duty
            wire wr_duty = wr_en && (reg_addr == (ADDR_DUTY_A + AW'(gi)));
            always_ff @(posedge clock or negedge rst_ni) begin
                if (!rst_ni) begin
                    duty_q[gi] <= DUTY_RST;
                end else if (wr_duty) begin
                    duty_q[gi] <= reg_wdata[CW-1:0];
                end
            end
        end
    endgenerate

    function automatic logic [DW-1:0] read_mux(input logic [AW-1:0] addr);
        logic [DW-1:0] v;
        v = '0;
        case (addr)
            ADDR_CTRL: v = DW'(ctrl_q);
            ADDR_CAL: v = DW'(cal_q);
            ADDR_PERIOD: v = DW'(period_q);
            ADDR_DUTY_A: v = DW'(duty_q[0]);
            ADDR_DUTY_A + 4'h1: v = DW'(duty_q[1]);
            ADDR_DUTY_A + 4'h2: v = DW'(duty_q[2]);
            ADDR_DEAD: v = DW'(dead_q);
            ADDR_SYNC_PRD: v = DW'(meas_prd_q);
            ADDR_TRIM: v = DW'(trim_q);
            default: v = '0;
        endcase
        return v;
    endfunction

    wire [DW-1:0] rdata_d = rd_en ? read_mux(reg_addr) : '0;
    always_ff @(posedge clock or negedge rst_ni) begin
        if (!rst_ni) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata = rdata_q;

    // Edge detection on the sync pin and the serial clock; both are taken as synchronous.
    logic sync_q;
    logic sync_prev_q;
    logic sclk_q;
    logic sclk_prev_q;
    always_ff @(posedge clock or negedge rst_ni) begin
        if (!rst_ni) begin
            sync_q <= 1'b0;
            sync_prev_q <= 1'b0;
            sclk_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else begin
            sync_q <= phase_b_low_input_pin;
            sync_prev_q <= sync_q;
            sclk_q <= serial_clk_in;
            sclk_prev_q <= sclk_q;
        end
    end
    wire sync_rise = sync_q & ~sync_prev_q;
    wire sclk_rise = sclk_q & ~sclk_prev_q;

    // Sync method decode.
    wire sync_on = (ctrl_q.sync == SYNC_MEASURE) | (ctrl_q.sync == SYNC_PERIOD)
        | (ctrl_q.sync == SYNC_OSC) | (ctrl_q.sync == SYNC_OSC_PERIOD);
    wire sync_sets_period = (ctrl_q.sync == SYNC_PERIOD)
        | (ctrl_q.sync == SYNC_OSC_PERIOD);
    wire sync_cal = (ctrl_q.sync == SYNC_OSC) | (ctrl_q.sync == SYNC_OSC_PERIOD);

    // Sync period measurement in system clocks; the first edge only arms it.
    logic [MW-1:0] meas_cnt_q;
    logic edge_seen_q;
    wire capture = sync_rise & edge_seen_q & sync_on;
    wire [MW-1:0] meas_inc = (meas_cnt_q == MEAS_MAX) ? meas_cnt_q : meas_cnt_q + 16'h0001;
    wire [CW-1:0] meas_sat = (meas_cnt_q > MW'(PRD_MAX)) ? PRD_MAX : meas_cnt_q[CW-1:0];
    always_ff @(posedge clock or negedge rst_ni) begin
        if (!rst_ni) begin
            meas_cnt_q <= '0;
            edge_seen_q <= 1'b0;
            meas_prd_q <= '0;
        end else begin
            meas_cnt_q <= sync_rise ? 16'h0001 : meas_inc;
            edge_seen_q <= sync_on & (edge_seen_q | sync_rise);
            if (capture) begin
                meas_prd_q <= meas_sat;
            end
        end
    end

    // Reference counter.
    logic [CW-1:0] cnt_q;
    logic cnt_d_dir;
    logic dir_up_q;
    logic [CW-1:0] cnt_d;
    wire [CW-1:0] src_prd = sync_sets_period ? meas_prd_q : period_q;
    wire [CW-1:0] top = (ctrl_q.mode == CNT_UPDOWN && sync_sets_period) ?
        (src_prd >> 1) : src_prd;
    wire [CW-1:0] start_val = (ctrl_q.mode == CNT_UP) ? '0 : top;
    wire restart = ~ctrl_q.en | (sync_sets_period & sync_rise);

    always_comb begin
        cnt_d = cnt_q;
        cnt_d_dir = dir_up_q;
        if (restart) begin
            cnt_d = start_val;
            cnt_d_dir = 1'b0;
        end else begin
            case (ctrl_q.mode)
                CNT_UPDOWN: begin
                    if (top == '0) begin
                        cnt_d = '0;
                    end else if (!dir_up_q) begin
                        if (cnt_q == '0) begin
                            cnt_d = cnt_q + 12'h001;
                            cnt_d_dir = 1'b1;
                        end else begin
                            cnt_d = cnt_q - 12'h001;
                        end
                    end else if (cnt_q >= top) begin
                        cnt_d = cnt_q - 12'h001;
                        cnt_d_dir = 1'b0;
                    end else begin
                        cnt_d = cnt_q + 12'h001;
                    end
                end
                CNT_UP: begin
                    cnt_d = (cnt_q >= top) ? '0 : cnt_q + 12'h001;
                end
                CNT_DOWN: begin
                    cnt_d = (cnt_q == '0 || cnt_q > top) ? top : cnt_q - 12'h001;
                end
                default: begin
                    cnt_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_ni) begin
        if (!rst_ni) begin
            cnt_q <= '0;
            dir_up_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            dir_up_q <= cnt_d_dir;
        end
    end

    // Phase outputs with dead time. A falling side drops at once; the rising side
    // waits the dead time, so the two sides never overlap.
    generate
        for (gi = 0; gi < PHASES; gi++) begin : g_phase
            wire cmp = duty_q[gi] > cnt_q;
            wire raw_hs = ctrl_q.en & ctrl_q.hs_en[gi] & cmp;
            wire raw_ls = ctrl_q.en & ctrl_q.ls_en[gi] & ~cmp;
            logic raw_hs_q;
            logic raw_ls_q;
            logic [7:0] dt_q;
            ipg_gate_t gate_q;
            // Each phase owns its flops; the port is only wired here, never shared by processes.
            assign gate_out[gi] = gate_q;
            wire changed = (raw_hs != raw_hs_q) | (raw_ls != raw_ls_q);
            wire [7:0] dt_d = changed ? dead_q : ((dt_q == 8'h00) ? dt_q : dt_q - 8'h01);
            always_ff @(posedge clock or negedge rst_ni) begin
                if (!rst_ni) begin
                    raw_hs_q <= 1'b0;
                    raw_ls_q <= 1'b0;
                    dt_q <= 8'h00;
                    gate_q <= '0;
                end else begin
                    raw_hs_q <= raw_hs;
                    raw_ls_q <= raw_ls;
                    dt_q <= dt_d;
                    gate_q.hs <= raw_hs & (dt_d == 8'h00);
                    gate_q.ls <= raw_ls & (dt_d == 8'h00);
                end
            end
        end
    endgenerate

    // Serial clock calibration: time a programmed number of serial clock cycles.
    ipg_cal_state_t cal_st_q;
    logic [MW-1:0] cal_sys_q;
    logic [8:0] cal_edges_q;
    wire [8:0] cal_cycles = 9'({4'h0, cal_q.cycles_code} + 5'h01) << CAL_CYC_SHIFT;
    wire [19:0] cal_meas = 20'(cal_sys_q) * 20'(cal_q.freq_mhz);
    wire [19:0] cal_expect = 20'(cal_cycles) * 20'(SYS_NOM_MHZ);
    wire sclk_mode = ctrl_q.sync == SYNC_SCLK;

    always_ff @(posedge clock or negedge rst_ni) begin
        if (!rst_ni) begin
            cal_st_q <= CAL_WAIT;
            cal_sys_q <= '0;
            cal_edges_q <= '0;
        end else if (!sclk_mode) begin
            cal_st_q <= CAL_WAIT;
        end else begin
            case (cal_st_q)
                CAL_WAIT: begin
                    cal_sys_q <= '0;
                    cal_edges_q <= '0;
                    if (sclk_rise) begin
                        cal_st_q <= CAL_RUN;
                    end
                end
                CAL_RUN: begin
                    cal_sys_q <= (cal_sys_q == MEAS_MAX) ? cal_sys_q : cal_sys_q + 16'h0001;
                    if (sclk_rise) begin
                        cal_edges_q <= cal_edges_q + 9'h001;
                        if (cal_edges_q + 9'h001 >= cal_cycles) begin
                            cal_st_q <= CAL_ADJ;
                        end
                    end
                end
                CAL_ADJ: begin
                    cal_st_q <= CAL_WAIT;
                end
                default: begin
                    cal_st_q <= CAL_WAIT;
                end
            endcase
        end
    end

    // Trim steps by one per measurement; a slow clock counts short and is trimmed up.
    wire sync_adj = capture & sync_cal;
    wire cal_adj = sclk_mode & (cal_st_q == CAL_ADJ);
    wire trim_up = (sync_adj & (meas_cnt_q < SYNC_CAL_COUNT))
        | (cal_adj & (cal_meas < cal_expect));
    wire trim_dn = (sync_adj & (meas_cnt_q > SYNC_CAL_COUNT))
        | (cal_adj & (cal_meas > cal_expect));
    always_ff @(posedge clock or negedge rst_ni) begin
        if (!rst_ni) begin
            trim_q <= TRIM_RST;
        end else if (trim_up && trim_q != TRIM_MAX) begin
            trim_q <= trim_q + 8'h01;
        end else if (trim_dn && trim_q != TRIM_MIN) begin
            trim_q <= trim_q - 8'h01;
        end
    end
    assign osc_trim = trim_q;

endmodule

`default_nettype wire

// [tb/ipg_core_monitor.sv]
// Port-level assertion checker for the internal PWM generator.
`timescale 1ns/10ps
`default_nettype none
module ipg_core_monitor
    import ipg_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic chip_select_n,
    input wire logic [ipg_pkg::AW-1:0] reg_addr,
    input wire logic [ipg_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ipg_pkg::DW-1:0] reg_rdata,
    input wire logic phase_b_low_input_pin,
    input wire logic serial_clk_in,
    input wire ipg_pkg::ipg_gate_t [ipg_pkg::PHASES-1:0] gate_out,
    input wire logic [7:0] osc_trim
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic en_q;
    logic [CW-1:0] period_q;
    logic wr_ok;
    logic [2:0] hs_all;
    logic [2:0] ls_all;
    assign wr_ok = reg_wr && !chip_select_n;
    assign hs_all = {gate_out[2].hs, gate_out[1].hs, gate_out[0].hs};
    assign ls_all = {gate_out[2].ls, gate_out[1].ls, gate_out[0].ls};
    // Shadows of the enable bit and period, so outputs can be tied to what was written.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
            period_q <= PERIOD_RST;
        end else begin
            en_q <= (wr_ok && reg_addr == ADDR_CTRL) ? reg_wdata[0] : en_q;
            period_q <= (wr_ok && reg_addr == ADDR_PERIOD) ? reg_wdata[CW-1:0] : period_q;
        end
    end
    sequence rd_of(logic [AW-1:0] a);
        reg_rd && !chip_select_n && reg_addr == a;
    endsequence
    sequence hs_dropped;
        $fell(gate_out[0].hs);
    endsequence
    sequence ls_dropped;
        $fell(gate_out[0].ls);
    endsequence
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside answer cycle");
    cs_refused_a: assert property (reg_rd && chip_select_n |=> reg_rdata == '0)
        else $error("read answered while deselected");
    period_read_a: assert property (rd_of(ADDR_PERIOD) |=> reg_rdata == {4'h0, period_q})
        else $error("period readback wrong");
    sync_width_a: assert property (rd_of(ADDR_SYNC_PRD) |=> reg_rdata[15:12] == 4'h0)
        else $error("measured period wider than 12 bits");
    trim_read_a: assert property (rd_of(ADDR_TRIM) |=> reg_rdata == {8'h00, $past(osc_trim)})
        else $error("trim readback wrong");
    trim_step_a: assert property ($changed(osc_trim) |-> (osc_trim - $past(osc_trim)) inside {8'h01, 8'hff})
        else $error("trim moved by more than one");
    no_overlap_a: assert property ((hs_all & ls_all) == 3'h0)
        else $error("both sides on in one phase");
    ls_dead_a: assert property (hs_dropped |-> !gate_out[0].ls [*4])
        else $error("low side rose inside dead time");
    hs_dead_a: assert property (ls_dropped |-> !gate_out[0].hs [*4])
        else $error("high side rose inside dead time");
    disabled_a: assert property (!en_q [*3] |-> hs_all == 3'h0)
        else $error("high side on while disabled");
endmodule

bind ipg_core ipg_core_monitor u_monitor (
    .clock(clock), .rst_n(rst_n), .chip_select_n(chip_select_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .phase_b_low_input_pin(phase_b_low_input_pin), .serial_clk_in(serial_clk_in),
    .gate_out(gate_out), .osc_trim(osc_trim)
);
`default_nettype wire

// [tb/ipg_mcu_model.sv]
// Controller-side model driving the sync pin and the serial clock.
`timescale 1ns/10ps
`default_nettype none
module ipg_mcu_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [15:0] sync_period,
    input wire logic sync_on,
    input wire logic sclk_on,
    output logic sync_pin,
    output logic sclk_pin
);
    logic [15:0] cnt_q;
    // Each line is driven low while its enable is off, so both rest low while unused.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0000;
            sync_pin <= 1'b0;
            sclk_pin <= 1'b0;
        end else begin
            cnt_q <= (cnt_q + 16'h0001 >= sync_period) ? 16'h0000 : cnt_q + 16'h0001;
            sync_pin <= sync_on && (cnt_q < (sync_period >> 1));
            sclk_pin <= sclk_on && !sclk_pin;
        end
    end
endmodule
`default_nettype wire

// [tb/internal_pwm_generator_sync_tb_top.sv]
// Self-checking testbench for the internal PWM generator.
`timescale 1ns/10ps
`default_nettype none
module internal_pwm_generator_sync_tb_top;
    import ipg_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n = 1'b1;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DW-1:0] rdata;
    logic sync_pin;
    logic sclk_pin;
    ipg_gate_t [PHASES-1:0] gate;
    logic [7:0] trim;
    logic [15:0] sync_period = 16'h0040;
    logic sync_on = 1'b0;
    logic sclk_on = 1'b0;
    int bad_count = 0;
    int comparisons = 0;
    int hs, ls, ri;
    logic [DW-1:0] v, t0;
    logic [DW-1:0] rst_tab [9] = '{16'h0fc0, 16'h0004, 16'h01f4, 16'h0000, 16'h0000,
        16'h0000, 16'h0004, 16'h0000, 16'h0080};
    ipg_sync_t methods [5] = '{SYNC_MEASURE, SYNC_PERIOD, SYNC_OSC, SYNC_OSC_PERIOD, SYNC_SCLK};
    ipg_core dut (.clock(clock), .rst_n(rst_n), .chip_select_n(cs_n), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .phase_b_low_input_pin(sync_pin), .serial_clk_in(sclk_pin), .gate_out(gate),
        .osc_trim(trim));
    ipg_mcu_model u_mcu (.clock(clock), .rst_n(rst_n), .sync_period(sync_period),
        .sync_on(sync_on), .sclk_on(sclk_on), .sync_pin(sync_pin), .sclk_pin(sclk_pin));
    initial begin
        forever #50 clock = ~clock;
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string w, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", w, exp, got);
        end
    endtask
    task automatic rng(input string w, input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", w, lo, hi, got);
        end
    endtask
    // Strobes drop with a gap cycle so no signal is assigned twice in one step.
    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge clock);
    endtask
    task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        logic [DW-1:0] d;
        rd_reg(a, d);
        check("register", exp, d);
    endtask
    task automatic pwm(input ipg_cnt_mode_t m, input ipg_sync_t s, input logic e,
        input logic [11:0] duty);
        wr_reg(ADDR_PERIOD, 16'h001f);
        wr_reg(ADDR_DUTY_A, {4'h0, duty});
        wr_reg(ADDR_CTRL, {4'h0, 6'h3f, s, m, e});
        repeat (64) @(posedge clock);
    endtask
    task automatic count(input int n);
        logic prev;
        hs = 0;
        ls = 0;
        ri = 0;
        prev = 1'b1;
        repeat (n) begin
            @(posedge clock);
            #1;
            hs += int'(gate[0].hs === 1'b1);
            ls += int'(gate[0].ls === 1'b1);
            ri += int'(gate[0].hs === 1'b1 && prev !== 1'b1);
            prev = gate[0].hs;
        end
        @(posedge clock);
    endtask
    // Whole sequence needs roughly 26000 cycles; the limit leaves margin.
    initial begin
        #(45000 * 100);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        cs_n <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i != 7) rd_chk(AW'(i), rst_tab[i]);
        end
        rd_chk(4'hf, 16'h0000);
        wr_reg(ADDR_TRIM, 16'h0012);
        rd_chk(ADDR_TRIM, 16'h0080);
        cs_n <= 1'b1;
        wr_reg(ADDR_PERIOD, 16'h0033);
        rd_chk(ADDR_PERIOD, 16'h0000);
        cs_n <= 1'b0;
        rd_chk(ADDR_PERIOD, 16'h01f4);
        wr_reg(ADDR_DEAD, 16'h0002);
        rd_chk(ADDR_DEAD, 16'h0002);
        wr_reg(ADDR_DEAD, 16'h0004);
        rd_chk(ADDR_DEAD, 16'h0004);
        for (int i = 0; i < 5; i++) begin
            wr_reg(ADDR_CTRL, {10'h03f, methods[i], 3'h0});
            rd_chk(ADDR_CTRL, {10'h03f, methods[i], 3'h0});
        end
        for (int i = 0; i < 3; i++) begin
            pwm(ipg_cnt_mode_t'(i), SYNC_OFF, 1'b1, 12'h010);
            count(320);
            rng("rises", (i == 0) ? 4 : 9, (i == 0) ? 6 : 11, ri);
            rng("high side", 100, 170, hs);
            rng("low side", 60, 170, ls);
            rng("dead gap", 0, 328 - 8 * ri, hs + ls);
        end
        pwm(CNT_UP, SYNC_OFF, 1'b1, 12'h020);
        count(320);
        rng("full duty", 320, 320, hs + 320 * ls);
        pwm(CNT_UP, SYNC_OFF, 1'b0, 12'h020);
        count(320);
        rng("disabled", 0, 0, hs + ls);
        sync_on <= 1'b1;
        pwm(CNT_UP, SYNC_MEASURE, 1'b0, 12'h010);
        repeat (200) @(posedge clock);
        rd_chk(ADDR_SYNC_PRD, 16'h0040);
        pwm(CNT_UP, SYNC_PERIOD, 1'b1, 12'h014);
        count(384);
        rng("sync rises", 5, 7, ri);
        rng("sync high", 80, 125, hs);
        sync_period <= 16'd5000;
        pwm(CNT_UP, SYNC_MEASURE, 1'b0, 12'h010);
        repeat (12000) @(posedge clock);
        rd_chk(ADDR_SYNC_PRD, 16'h0fff);
        sync_period <= 16'd1010;
        pwm(CNT_UP, SYNC_OSC_PERIOD, 1'b1, 12'h014);
        repeat (3000) @(posedge clock);
        count(2020);
        rng("cal rises", 1, 3, ri);
        rd_reg(ADDR_TRIM, t0);
        check("trim lowered", 16'h0001, {15'h0, t0 < 16'h0080});
        sync_period <= 16'd990;
        pwm(CNT_UP, SYNC_OSC, 1'b0, 12'h010);
        repeat (5000) @(posedge clock);
        rd_reg(ADDR_TRIM, v);
        check("trim raised", 16'h0001, {15'h0, v > t0});
        sync_on <= 1'b0;
        sclk_on <= 1'b1;
        wr_reg(ADDR_CAL, 16'h0005);
        rd_chk(ADDR_CAL, 16'h0005);
        rd_reg(ADDR_TRIM, t0);
        pwm(CNT_UP, SYNC_SCLK, 1'b0, 12'h010);
        repeat (800) @(posedge clock);
        rd_reg(ADDR_TRIM, v);
        check("sclk trim raised", 16'h0001, {15'h0, v > t0});
        summarize();
    end
endmodule
`default_nettype wire
